// file: rtl/mar_acq_results.sv
// acquisition sequencer and result registers of the eight-input monitor
// ----------------------------------------------------------------
// How it works
// RL1 - repeat mode keeps acquiring after one trigger
// RL2 - no result updates during a serial read
// RL3 - upper and lower bytes written together
// RL4 - no read timeout; master must end reads
// RL5 - trigger one measurement or whole configuration
// RL6 - measurements always in one fixed order
// RL7 - new result sets valid and status bits
// RL8 - addressing data register clears both flags
// RL9 - default: internal temperature plus eight singles
// RL10 - inputs high impedance until configured and triggered
// RL11 - remote temperature lands in odd input register
// RL12 - diode voltage lands in even input register
// RL13 - 8-bit upper/lower, 13-bit value, status bits
// RL14 - temperature Celsius or Kelvin, sixteenth degree
// RL15 - temperature upper bit 7 is data valid
// RL16 - temperature upper bits 4..0 hold bits 12..8
// RL17 - lower byte holds bits 7..0, value/16
// RL18 - Kelvin results never negative
// RL19 - diode voltage only for remote diodes
// RL20 - order inputs 1..8, internal, supply
// RL21 - conversions start only on trigger write
// RL22 - undervoltage resets all registers to zero
// RL23 - voltage upper: sign bit 6, bits 5..0
// RL24 - repeat restarts at first slot after reads; code holds the next start until the read ends, then runs that slot
// ----------------------------------------------------------------
`default_nettype none
module mar_acq_results
  import mar_pkg::*;
(
  input  wire logic           i_clock,
  input  wire logic           i_rst_n,
  input  wire logic           i_undervoltage_lockout,
  input  wire logic [7:0]     i_reg_addr,
  input  wire logic           i_reg_wr,
  input  wire logic [7:0]     i_reg_wdata,
  input  wire logic           i_reg_addressed,
  input  wire logic           i_read_active,
  output var  logic [7:0]     o_reg_rdata,
  output var  logic           o_conv_start,
  output var  mar_conv_req_t  o_conv_req,
  input  wire logic           i_conv_done,
  input  wire mar_conv_data_t i_conv_data,
  output var  logic [7:0]     o_input_enable,
  output var  logic           o_busy
);

  // ----------------------------------------------------------------
  // reset release
  // ----------------------------------------------------------------
  // lockout is folded into the asynchronous reset so it clears everything
  logic       rst_raw_n;
  logic [1:0] rst_sync;
  logic       rst_n;

  assign rst_raw_n = i_rst_n & ~i_undervoltage_lockout; // [RL22]

  always_ff @(posedge i_clock or negedge rst_raw_n) begin
    if (!rst_raw_n) begin
      rst_sync <= 2'b00;
    end else begin
      rst_sync <= {rst_sync[0], 1'b1};
    end
  end

  assign rst_n = rst_sync[1];

  // ----------------------------------------------------------------
  // decode helpers
  // ----------------------------------------------------------------
  function automatic logic [3:0] pair_nibble(input logic [3:0] slot,
                                             input logic [7:0] pa,
                                             input logic [7:0] pb);
    logic [7:0] pr;
    pr = slot[2] ? pb : pa;
    return slot[1] ? pr[7:4] : pr[3:0];
  endfunction

  function automatic logic slot_enabled(input logic [3:0] slot,
                                        input logic [7:0] pa,
                                        input logic [7:0] pb,
                                        input logic [7:0] gl);
    logic [3:0] nib;
    nib = pair_nibble(slot, pa, pb);
    if (slot == MAR_SLOT_TINT) begin
      return ~gl[MAR_GLB_TINT_SKIP]; // [RL9]
    end else if (slot == MAR_SLOT_SUPPLY) begin
      return gl[MAR_GLB_SUPPLY_EN];
    end else if (slot >= MAR_SLOT_END) begin
      return 1'b0;
    end
    // a differential pair reports once, in the odd input's slot
    return ~nib[MAR_PAIR_SKIP_BIT] &
           ~(nib[MAR_PAIR_DIFF_BIT] & ~nib[MAR_PAIR_TEMP_BIT] & slot[0]);
  endfunction

  function automatic mar_meas_t slot_kind(input logic [3:0] slot,
                                          input logic [7:0] pa,
                                          input logic [7:0] pb,
                                          input logic [7:0] gl);
    logic [3:0] nib;
    nib = pair_nibble(slot, pa, pb);
    if (slot == MAR_SLOT_TINT) begin
      return gl[MAR_GLB_TINT_K_BIT] ? MEAS_TINT_K : MEAS_TINT_C; // [RL14]
    end else if (slot == MAR_SLOT_SUPPLY) begin
      return MEAS_SUPPLY;
    end else if (nib[MAR_PAIR_TEMP_BIT]) begin
      if (!slot[0]) begin
        return nib[MAR_PAIR_KELVIN_BIT] ? MEAS_TEMP_K : MEAS_TEMP_C; // [RL11] [RL14]
      end
      return MEAS_DIODE_V; // [RL12] [RL19]
    end else if (nib[MAR_PAIR_DIFF_BIT]) begin
      return MEAS_DIFF;
    end
    return MEAS_SINGLE;
  endfunction

  // upper 7 bits and lower byte; the valid bit is added by the slot
  function automatic logic [14:0] format_result(input mar_meas_t kind,
                                                input mar_conv_data_t d);
    logic [12:0] t;
    t = d.value[12:0];
    if (kind == MEAS_TEMP_C || kind == MEAS_TEMP_K ||
        kind == MEAS_TINT_C || kind == MEAS_TINT_K) begin
      if ((kind == MEAS_TEMP_K || kind == MEAS_TINT_K) && t[12]) begin
        t = 13'h0000; // [RL18]
      end
      return {2'b00, t[12:8], t[7:0]}; // [RL13] [RL16] [RL17]
    end
    return {d.sign, d.value[13:8], d.value[7:0]}; // [RL23]
  endfunction

  // ----------------------------------------------------------------
  // control registers
  // ----------------------------------------------------------------
  logic [7:0] pair_a;
  logic [7:0] pair_b;
  logic [7:0] global_ctrl;
  logic       trig_write;

  assign trig_write = i_reg_wr && (i_reg_addr == MAR_ADDR_TRIGGER);

  always_ff @(posedge i_clock or negedge rst_n) begin
    if (!rst_n) begin
      pair_a      <= MAR_RST_BYTE; // [RL22]
      pair_b      <= MAR_RST_BYTE;
      global_ctrl <= MAR_RST_BYTE;
    end else if (i_reg_wr) begin
      if (i_reg_addr == MAR_ADDR_PAIR_A) begin
        pair_a <= i_reg_wdata;
      end else if (i_reg_addr == MAR_ADDR_PAIR_B) begin
        pair_b <= i_reg_wdata;
      end else if (i_reg_addr == MAR_ADDR_GLOBAL) begin
        global_ctrl <= i_reg_wdata;
      end
    end
  end

  // ----------------------------------------------------------------
  // sequencer
  // ----------------------------------------------------------------
  typedef enum logic [2:0] {
    ST_IDLE,
    ST_FIND,
    ST_START,
    ST_WAIT,
    ST_COMMIT
  } mar_state_t;

  mar_state_t     state;
  logic [3:0]     slot;
  logic           one_only;
  mar_conv_data_t held;
  logic           commit;
  logic           triggered;

  // results only land between serial reads; no timeout exists here
  assign commit = (state == ST_COMMIT) && !i_read_active; // [RL2] [RL4]

  always_ff @(posedge i_clock or negedge rst_n) begin
    if (!rst_n) begin
      state    <= ST_IDLE;
      slot     <= MAR_RST_SLOT;
      one_only <= 1'b0;
    end else begin
      case (state)
        ST_IDLE: begin
          if (trig_write) begin // [RL21]
            one_only <= i_reg_wdata[MAR_TRIG_ONE_BIT]; // [RL5]
            slot     <= i_reg_wdata[MAR_TRIG_ONE_BIT] ? i_reg_wdata[3:0] : MAR_RST_SLOT;
            state    <= i_reg_wdata[MAR_TRIG_ONE_BIT] ? ST_START : ST_FIND;
          end
        end
        ST_FIND: begin
          if (slot >= MAR_SLOT_END) begin
            if (global_ctrl[MAR_GLB_REPEAT_BIT]) begin
              slot <= MAR_RST_SLOT; // [RL1] [RL24]
            end else begin
              state <= ST_IDLE;
            end
          end else if (slot_enabled(slot, pair_a, pair_b, global_ctrl)) begin
            state <= ST_START;
          end else begin
            slot <= slot + 4'h1; // [RL6] [RL20]
          end
        end
        ST_START: begin
          if (one_only && slot >= MAR_SLOT_END) begin
            state <= ST_IDLE;
          end else if (!i_read_active) begin // [RL24]
            state <= ST_WAIT;
          end
        end
        ST_WAIT: begin
          if (i_conv_done) begin
            state <= ST_COMMIT;
          end
        end
        ST_COMMIT: begin
          if (commit) begin
            if (one_only) begin
              state <= global_ctrl[MAR_GLB_REPEAT_BIT] ? ST_START : ST_IDLE; // [RL1]
            end else begin
              slot  <= slot + 4'h1; // [RL20]
              state <= ST_FIND;
            end
          end
        end
        default: begin
          state <= ST_IDLE;
        end
      endcase
    end
  end

  // converter request
  always_ff @(posedge i_clock or negedge rst_n) begin
    if (!rst_n) begin
      o_conv_start <= 1'b0;
      o_conv_req   <= '{kind: MEAS_SINGLE, slot: MAR_RST_SLOT};
    end else begin
      o_conv_start <= (state == ST_START) && !i_read_active &&
                      (slot < MAR_SLOT_END);
      // request only moves with its start pulse, so it stands while frozen
      if ((state == ST_START) && !i_read_active && (slot < MAR_SLOT_END)) begin
        o_conv_req <= '{kind: slot_kind(slot, pair_a, pair_b, global_ctrl),
                        slot: slot};
      end
    end
  end

  // a finished conversion waits here while a read freezes the registers
  always_ff @(posedge i_clock or negedge rst_n) begin
    if (!rst_n) begin
      held <= '{sign: 1'b0, value: 14'h0000};
    end else if (state == ST_WAIT && i_conv_done) begin
      held <= i_conv_data;
    end
  end

  // ----------------------------------------------------------------
  // input pin enables
  // ----------------------------------------------------------------
  always_ff @(posedge i_clock or negedge rst_n) begin
    if (!rst_n) begin
      triggered <= 1'b0;
    end else if (trig_write) begin
      triggered <= 1'b1;
    end
  end

  always_ff @(posedge i_clock or negedge rst_n) begin
    if (!rst_n) begin
      o_input_enable <= MAR_RST_BYTE;
    end else begin
      for (int i = 0; i < MAR_NUM_INPUTS; i++) begin
        // both legs of a paired measurement stay connected
        o_input_enable[i] <= triggered && // [RL10]
          (slot_enabled(4'(i), pair_a, pair_b, global_ctrl) ||
           slot_enabled(4'(i ^ 1), pair_a, pair_b, global_ctrl));
      end
    end
  end

  assign o_busy = (state != ST_IDLE);

  // ----------------------------------------------------------------
  // result registers
  // ----------------------------------------------------------------
  mar_result_t results [MAR_NUM_SLOTS];
  logic [MAR_NUM_SLOTS-1:0] valid;
  logic [14:0]              new_bytes;
  logic [7:0]               data_off;

  assign new_bytes = format_result(o_conv_req.kind, held);
  assign data_off  = i_reg_addr - MAR_ADDR_DATA_BASE;

  generate
    for (genvar g = 0; g < MAR_NUM_SLOTS; g++) begin : g_slot
      logic hit;
      assign hit = i_reg_addressed && (i_reg_addr >= MAR_ADDR_DATA_BASE) &&
                   (i_reg_addr <= MAR_ADDR_DATA_LAST) && (data_off[7:1] == 7'(g));
      mar_result_slot u_slot (
        .i_clock  (i_clock),
        .i_rst_n  (rst_n),
        .i_load   (commit && (o_conv_req.slot == 4'(g))), // [RL3] [RL7]
        .i_bytes  (new_bytes),
        .i_clear  (hit), // [RL8] [RL15]
        .o_result (results[g]),
        .o_valid  (valid[g])
      );
    end
  endgenerate

  // ----------------------------------------------------------------
  // read data
  // ----------------------------------------------------------------
  always_ff @(posedge i_clock or negedge rst_n) begin
    if (!rst_n) begin
      o_reg_rdata <= MAR_RST_BYTE;
    end else if (i_reg_addr == MAR_ADDR_STATUS_LO) begin
      o_reg_rdata <= valid[7:0]; // [RL7]
    end else if (i_reg_addr == MAR_ADDR_STATUS_HI) begin
      o_reg_rdata <= {o_busy, 5'h00, valid[9:8]};
    end else if (i_reg_addr == MAR_ADDR_PAIR_A) begin
      o_reg_rdata <= pair_a;
    end else if (i_reg_addr == MAR_ADDR_PAIR_B) begin
      o_reg_rdata <= pair_b;
    end else if (i_reg_addr == MAR_ADDR_GLOBAL) begin
      o_reg_rdata <= global_ctrl;
    end else if (i_reg_addr >= MAR_ADDR_DATA_BASE && i_reg_addr <= MAR_ADDR_DATA_LAST) begin
      o_reg_rdata <= data_off[0] ? results[data_off[4:1]].lower
                                 : results[data_off[4:1]].upper;
    end else begin
      o_reg_rdata <= MAR_RST_BYTE;
    end
  end

endmodule
`default_nettype wire

// file: inc/mar_pkg.sv
// shared constants and types for the monitor acquisition and result block
`default_nettype none
package mar_pkg;

  // ----------------------------------------------------------------
  // register offsets
  // ----------------------------------------------------------------
  localparam logic [7:0] MAR_ADDR_STATUS_LO = 8'h00;
  localparam logic [7:0] MAR_ADDR_TRIGGER   = 8'h01;
  localparam logic [7:0] MAR_ADDR_STATUS_HI = 8'h02;
  localparam logic [7:0] MAR_ADDR_PAIR_A    = 8'h06;
  localparam logic [7:0] MAR_ADDR_PAIR_B    = 8'h07;
  localparam logic [7:0] MAR_ADDR_GLOBAL    = 8'h08;
  localparam logic [7:0] MAR_ADDR_DATA_BASE = 8'h0A;
  localparam logic [7:0] MAR_ADDR_DATA_LAST = 8'h1D;

  // ----------------------------------------------------------------
  // reset values
  // ----------------------------------------------------------------
  localparam logic [7:0] MAR_RST_BYTE = 8'h00;
  localparam logic [3:0] MAR_RST_SLOT = 4'h0;

  // ----------------------------------------------------------------
  // field positions
  // ----------------------------------------------------------------
  localparam int MAR_PAIR_TEMP_BIT    = 0;
  localparam int MAR_PAIR_KELVIN_BIT  = 1;
  localparam int MAR_PAIR_DIFF_BIT    = 2;
  localparam int MAR_PAIR_SKIP_BIT    = 3;
  localparam int MAR_GLB_REPEAT_BIT   = 0;
  localparam int MAR_GLB_TINT_K_BIT   = 1;
  localparam int MAR_GLB_TINT_SKIP    = 2;
  localparam int MAR_GLB_SUPPLY_EN    = 3;
  localparam int MAR_TRIG_ONE_BIT     = 7;
  localparam int MAR_RES_VALID_BIT    = 7;
  localparam int MAR_HI_BUSY_BIT      = 7;

  // ----------------------------------------------------------------
  // slots: inputs 1..8 are slots 0..7
  // ----------------------------------------------------------------
  localparam int         MAR_NUM_SLOTS    = 10;
  localparam int         MAR_NUM_INPUTS   = 8;
  localparam logic [3:0] MAR_SLOT_TINT    = 4'h8;
  localparam logic [3:0] MAR_SLOT_SUPPLY  = 4'h9;
  localparam logic [3:0] MAR_SLOT_END     = 4'hA;

  typedef enum logic [2:0] {
    MEAS_SINGLE,
    MEAS_DIFF,
    MEAS_TEMP_C,
    MEAS_TEMP_K,
    MEAS_DIODE_V,
    MEAS_TINT_C,
    MEAS_TINT_K,
    MEAS_SUPPLY
  } mar_meas_t;

  typedef struct packed {
    mar_meas_t  kind;
    logic [3:0] slot;
  } mar_conv_req_t;

  typedef struct packed {
    logic        sign;
    logic [13:0] value;
  } mar_conv_data_t;

  typedef struct packed {
    logic [7:0] upper;
    logic [7:0] lower;
  } mar_result_t;

endpackage
`default_nettype wire

// file: rtl/mar_result_slot.sv
// one result register pair with its data-valid flag
`default_nettype none
module mar_result_slot
  import mar_pkg::*;
(
  input  wire logic        i_clock,
  input  wire logic        i_rst_n,
  input  wire logic        i_load,
  input  wire logic [14:0] i_bytes,
  input  wire logic        i_clear,
  output var  mar_result_t o_result,
  output var  logic        o_valid
);

  logic [14:0] bytes;

  always_ff @(posedge i_clock or negedge i_rst_n) begin
    if (!i_rst_n) begin
      bytes <= 15'h0000;
    end else if (i_load) begin
      bytes <= i_bytes;
    end
  end

  // set beats a clear landing in the same cycle
  always_ff @(posedge i_clock or negedge i_rst_n) begin
    if (!i_rst_n) begin
      o_valid <= 1'b0;
    end else if (i_load) begin
      o_valid <= 1'b1;
    end else if (i_clear) begin
      o_valid <= 1'b0;
    end
  end

  assign o_result = '{upper: {o_valid, bytes[14:8]}, lower: bytes[7:0]};

endmodule
`default_nettype wire

// file: verif/mar_acq_results_asserts.sv
// assertion checker for the acquisition and result block
`default_nettype none
module mar_acq_results_asserts
  import mar_pkg::*;
(
  input wire logic          i_clock,
  input wire logic          i_rst_n,
  input wire logic          i_undervoltage_lockout,
  input wire logic [7:0]    i_reg_addr,
  input wire logic          i_reg_wr,
  input wire logic          i_reg_addressed,
  input wire logic          i_read_active,
  input wire logic [7:0]    o_reg_rdata,
  input wire logic          o_conv_start,
  input wire mar_conv_req_t o_conv_req,
  input wire logic [7:0]    o_input_enable,
  input wire logic          o_busy
);
  timeunit 1ns;
  timeprecision 1ns;
  // ----------------------------------------------------------------
  // helper state
  // ----------------------------------------------------------------
  logic      trig_seen;
  wire logic trig_wr;
  wire logic hi_hit;
  assign trig_wr = i_reg_wr && (i_reg_addr == MAR_ADDR_TRIGGER);
  assign hi_hit  = i_reg_addressed && !i_reg_addr[0] && !o_busy
                   && (i_reg_addr >= MAR_ADDR_DATA_BASE) && (i_reg_addr <= MAR_ADDR_DATA_LAST);
  always_ff @(posedge i_clock or negedge i_rst_n or posedge i_undervoltage_lockout) begin
    if (!i_rst_n || i_undervoltage_lockout) begin
      trig_seen <= 1'h0;
    end else if (trig_wr) begin
      trig_seen <= 1'h1;
    end
  end
  default clocking @(posedge i_clock); endclocking
  default disable iff (!i_rst_n || i_undervoltage_lockout);
  property p_no_start_reading;
    i_read_active ##1 i_read_active |-> !o_conv_start;
  endproperty
  a_no_start_reading: assert property (p_no_start_reading) else $error("start in read");
  property p_busy_cause;
    $rose(o_busy) |-> $past(i_reg_wr) && ($past(i_reg_addr) == MAR_ADDR_TRIGGER);
  endproperty
  a_busy_cause: assert property (p_busy_cause) else $error("busy without trigger");
  property p_start_soon;
    $rose(o_busy) && !i_read_active |-> ##[1:12] o_conv_start;
  endproperty
  a_start_soon: assert property (p_start_soon) else $error("trigger gave no start");
  property p_start_busy;
    o_conv_start |-> o_busy ##1 !o_conv_start;
  endproperty
  a_start_busy: assert property (p_start_busy) else $error("bad start pulse");
  property p_req_hold;
    !o_conv_start |-> $stable(o_conv_req);
  endproperty
  a_req_hold: assert property (p_req_hold) else $error("request moved");
  property p_slot_range;
    o_conv_start |-> o_conv_req.slot < MAR_SLOT_END;
  endproperty
  a_slot_range: assert property (p_slot_range) else $error("slot out of range");
  property p_hiz;
    !trig_seen |-> o_input_enable == 8'h00;
  endproperty
  a_hiz: assert property (p_hiz) else $error("input enabled early");
  property p_clear;
    hi_hit ##1 ($stable(i_reg_addr) && !o_busy) |=> !o_reg_rdata[MAR_RES_VALID_BIT];
  endproperty
  a_clear: assert property (p_clear) else $error("valid not cleared");
  property p_lockout;
    disable iff (!i_rst_n)
    i_undervoltage_lockout |-> !o_busy && !o_conv_start && (o_reg_rdata == 8'h00);
  endproperty
  a_lockout: assert property (p_lockout) else $error("lockout not reset");
endmodule
bind mar_acq_results mar_acq_results_asserts u_chk (
  .i_clock(i_clock), .i_rst_n(i_rst_n), .i_undervoltage_lockout(i_undervoltage_lockout),
  .i_reg_addr(i_reg_addr), .i_reg_wr(i_reg_wr), .i_reg_addressed(i_reg_addressed),
  .i_read_active(i_read_active), .o_reg_rdata(o_reg_rdata), .o_conv_start(o_conv_start),
  .o_conv_req(o_conv_req), .o_input_enable(o_input_enable), .o_busy(o_busy)
);
`default_nettype wire

// file: verif/mar_conv_model.sv
// converter stand-in answering each conversion request
`default_nettype none
module mar_conv_model
  import mar_pkg::*;
(
  input  wire logic           i_clock,
  input  wire logic           i_rst_n,
  input  wire logic           i_start,
  input  wire mar_conv_req_t  i_req,
  input  wire logic           i_slow,
  output var  logic           o_done,
  output var  mar_conv_data_t o_data
);
  timeunit 1ns;
  timeprecision 1ns;
  int cnt;
  // data toggles outside the done pulse so stale values never match
  always @(posedge i_clock or negedge i_rst_n) begin
    if (!i_rst_n) begin
      cnt <= 0;
      o_done <= 1'h0;
      o_data <= '0;
    end else begin
      o_done <= (cnt == 1);
      o_data <= (cnt == 1) ? {1'h0, 3'h3, i_req.kind, 4'h0, i_req.slot} : ~o_data;
      if (i_start) begin
        cnt <= i_slow ? 40 : 3;
      end else if (cnt > 0) begin
        cnt <= cnt - 1;
      end
    end
  end
endmodule
`default_nettype wire

// file: verif/mar_acq_results_tb.sv
// self-checking bench for the acquisition and result block
`default_nettype none
`define CHK(a, e) begin samples_checked++; if ((a) !== (e)) begin fail_count++; \
  $display("mismatch %0t got %h exp %h", $time, a, e); end end
module mar_acq_results_tb
  import mar_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ns;
  logic           clock, rst_n, uv, wr, addressed, rd_act, slow, start, done, busy;
  logic [7:0]     addr, wdata, rdata, ien, v;
  mar_conv_req_t  req;
  mar_conv_data_t cdata;
  mar_conv_req_t  reqs[$];
  int             fail_count, samples_checked;
  mar_acq_results dut (.i_clock(clock), .i_rst_n(rst_n), .i_undervoltage_lockout(uv),
    .i_reg_addr(addr), .i_reg_wr(wr), .i_reg_wdata(wdata), .i_reg_addressed(addressed),
    .i_read_active(rd_act), .o_reg_rdata(rdata), .o_conv_start(start), .o_conv_req(req),
    .i_conv_done(done), .i_conv_data(cdata), .o_input_enable(ien), .o_busy(busy));
  mar_conv_model u_conv (.i_clock(clock), .i_rst_n(rst_n), .i_start(start), .i_req(req),
    .i_slow(slow), .o_done(done), .o_data(cdata));
  task automatic results;
    if (fail_count == 0 && samples_checked > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask
  task automatic wr_reg(input logic [7:0] a, input logic [7:0] d);
    addr = a;
    wdata = d;
    wr = 1'h1;
    @(negedge clock);
    wr = 1'h0;
    @(negedge clock);
  endtask
  // host read: the address phase also clears the slot's valid flag
  task automatic rd(input logic [7:0] a);
    addr = a;
    rd_act = 1'h1;
    @(negedge clock);
    v = rdata;
    addressed = 1'h1;
    @(negedge clock);
    addressed = 1'h0;
    rd_act = 1'h0;
    @(negedge clock);
  endtask
  task automatic rchk(input logic [7:0] a, input logic [7:0] e);
    rd(a);
    `CHK(v, e)
  endtask
  // k == 0 waits for idle, otherwise for k recorded starts
  task automatic wait_until(input int k);
    int n;
    n = 0;
    while ((k == 0 ? busy !== 1'h0 : reqs.size() < k) && n < 3000) begin
      @(negedge clock);
      n++;
    end
    if (n >= 3000) begin
      fail_count++;
      results();
    end
  endtask
  function automatic logic [7:0] exp_hi(input mar_meas_t k);
    logic [13:0] d;
    d = {3'h3, k, 8'h00};
    if (k inside {MEAS_TEMP_C, MEAS_TINT_C}) return {1'h1, 2'h0, d[12:8]};
    return {1'h1, 1'h0, d[13:8]};
  endfunction
  initial begin
    clock = 1'h0;
    forever #10 clock = ~clock;
  end
  // sampled mid-cycle, away from the edge that launches the pulse
  always @(negedge clock) begin
    if (start === 1'h1) reqs.push_back(req);
  end
  initial begin
    {rst_n, uv, wr, addressed, rd_act, slow, addr, wdata} = '0;
    fail_count = 0;
    samples_checked = 0;
    repeat (3) @(negedge clock);
    rst_n = 1'h1;
    repeat (4) @(negedge clock);
    rchk(MAR_ADDR_PAIR_A, 8'h00);
    rchk(MAR_ADDR_STATUS_LO, 8'h00);
    rchk(MAR_ADDR_DATA_BASE, 8'h00);
    rchk(MAR_ADDR_DATA_LAST, 8'h00);
    rchk(MAR_ADDR_TRIGGER, 8'h00);
    rchk(MAR_ADDR_PAIR_B, 8'h00);
    rchk(MAR_ADDR_GLOBAL, 8'h00);
    rchk(MAR_ADDR_STATUS_HI, 8'h00);
    `CHK(ien, 8'h00)
    wr_reg(MAR_ADDR_TRIGGER, 8'h00);
    wait_until(0);
    `CHK(reqs.size(), 9)
    `CHK(ien, 8'hFF)
    for (int i = 0; i < 9; i++) begin
      `CHK(reqs[i].slot, i[3:0])
      `CHK(reqs[i].kind, (i < 8) ? MEAS_SINGLE : MEAS_TINT_C)
    end
    rchk(MAR_ADDR_STATUS_LO, 8'hFF);
    rchk(MAR_ADDR_STATUS_HI, 8'h01);
    for (int i = 0; i < 9; i++) begin
      rchk(MAR_ADDR_DATA_BASE + 8'(2 * i), exp_hi((i < 8) ? MEAS_SINGLE : MEAS_TINT_C));
      rchk(MAR_ADDR_DATA_BASE + 8'(2 * i + 1), {4'h0, i[3:0]});
    end
    rchk(MAR_ADDR_STATUS_LO, 8'h00);
    rchk(MAR_ADDR_STATUS_HI, 8'h00);
    reqs.delete();
    wr_reg(MAR_ADDR_TRIGGER, 8'h83);
    wait_until(0);
    `CHK(reqs.size(), 1)
    `CHK(reqs[0].slot, 4'h3)
    rchk(8'h10, 8'h98);
    reqs.delete();
    slow = 1'h1;
    wr_reg(MAR_ADDR_TRIGGER, 8'h85);
    wait_until(1);
    addr = MAR_ADDR_STATUS_LO;
    rd_act = 1'h1;
    repeat (60) @(negedge clock);
    `CHK(rdata, 8'h00)
    rd_act = 1'h0; // the master always ends its read
    repeat (3) @(negedge clock);
    `CHK(rdata, 8'h20)
    slow = 1'h0;
    wait_until(0);
    rchk(8'h14, 8'h98);
    wr_reg(MAR_ADDR_PAIR_A, 8'h03);
    wr_reg(MAR_ADDR_GLOBAL, 8'h04);
    reqs.delete();
    wr_reg(MAR_ADDR_TRIGGER, 8'h00);
    wait_until(0);
    `CHK(reqs[0].kind, MEAS_TEMP_K)
    rchk(8'h0A, 8'h80);
    rchk(8'h0B, 8'h00);
    rd(8'h0C);
    `CHK(v[7], 1'h1)
    wr_reg(MAR_ADDR_PAIR_A, 8'h00);
    wr_reg(MAR_ADDR_GLOBAL, 8'h05);
    reqs.delete();
    wr_reg(MAR_ADDR_TRIGGER, 8'h00);
    wait_until(17);
    wr_reg(MAR_ADDR_GLOBAL, 8'h04);
    wait_until(0);
    `CHK(reqs[8].slot, 4'h0)
    `CHK(reqs[16].slot, 4'h0)
    `CHK(reqs.size() % 8, 0)
    wr_reg(MAR_ADDR_GLOBAL, 8'h02);
    reqs.delete();
    wr_reg(MAR_ADDR_TRIGGER, 8'h88);
    wait_until(0);
    `CHK(reqs[0].kind, MEAS_TINT_K)
    rchk(8'h1A, 8'h80);
    uv = 1'h1;
    repeat (2) @(negedge clock);
    uv = 1'h0;
    repeat (4) @(negedge clock);
    rchk(MAR_ADDR_GLOBAL, 8'h00);
    rchk(8'h0A, 8'h00);
    results();
  end
endmodule
`default_nettype wire
